// ===== shared/cefc_consts.vh
`ifndef CEFC_CONSTS_VH
`define CEFC_CONSTS_VH

// ---------------------------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------------------------
`define CEFC_FLAGS_IDX        8'h7F
`define CEFC_MASKS_IDX        8'h80
`define CEFC_POL_IDX          8'h81
`define CEFC_DB_IDX           8'h82
`define CEFC_ADDR_W           12
`define CEFC_IDX_TO_ADDR(i)   ({2'b00, (i), 2'b00})

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CEFC_NSRC             10
`define CEFC_BIT_MIC_DET      0
`define CEFC_BIT_MIC_SHRT     1
`define CEFC_BIT_FREQ_LOCK    2
`define CEFC_BIT_IN_SEVEN     3
`define CEFC_BIT_IN_EIGHT     4
`define CEFC_BIT_PIN_ONE      5
`define CEFC_BIT_PIN_TWO      6
`define CEFC_BIT_PIN_THREE    7
`define CEFC_BIT_SEQ          8
`define CEFC_BIT_BITCLK       9
`define CEFC_BIT_SUMMARY      10

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CEFC_FLAGS_RST        10'h000
`define CEFC_MASKS_RST        10'h3FF
`define CEFC_POL_RST          10'h000
`define CEFC_DB_RST           10'h000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CEFC_CLK_MHZ          100
`define CEFC_DB_TIME_NS       1000
`define CEFC_DB_CYCLES        ((`CEFC_DB_TIME_NS * `CEFC_CLK_MHZ) / 1000)
`define CEFC_DB_CNT_W         8
`define CEFC_DB_LAST          8'h63

`endif

// ===== design/cefc_debounce.v
`include "cefc_consts.vh"

module cefc_debounce (
	input  wire CLK,
	input  wire RST_N,
	input  wire LVL_IN,
	input  wire DB_EN,
	output wire LVL_OUT
);

	// -----------------------------------------------------------
	// Stability counter
	// -----------------------------------------------------------
	// Last count of the debounce time, one less than its cycles
	localparam [`CEFC_DB_CNT_W-1:0] DB_LAST = `CEFC_DB_LAST;

	reg                      held_r;
	reg [`CEFC_DB_CNT_W-1:0] cnt_r;
	reg                      held_nxt;
	reg [`CEFC_DB_CNT_W-1:0] cnt_nxt;

	// A change must stand for the whole debounce time before it
	// passes; any spike shorter than that restarts the count.
	always @* begin
		held_nxt = held_r;
		cnt_nxt  = {`CEFC_DB_CNT_W{1'b0}};
		if (!DB_EN) begin
			held_nxt = LVL_IN;
		end else if (LVL_IN != held_r) begin
			if (cnt_r == DB_LAST) begin
				held_nxt = LVL_IN;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			held_r <= 1'b0;
			cnt_r  <= {`CEFC_DB_CNT_W{1'b0}};
		end else begin
			held_r <= held_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	assign LVL_OUT = held_r;

endmodule // cefc_debounce

// ===== design/cefc_top.v
// Decided for this implementation: register access over AHB-Lite.
`include "cefc_consts.vh"

module cefc_top (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire        BITCLK_PIN,
	input  wire        SEQ_BUSY,
	input  wire        PIN_THREE,
	input  wire        PIN_TWO,
	input  wire        PIN_ONE,
	input  wire        INPUT_EIGHT,
	input  wire        INPUT_SEVEN,
	input  wire        FREQ_LOCK,
	input  wire        MIC_SHORT,
	input  wire        MIC_DETECT,
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output wire        HREADYOUT,
	output wire        HRESP,
	output wire [31:0] HRDATA,
	output wire        IRQ
);

	localparam N = `CEFC_NSRC;
	localparam [`CEFC_ADDR_W-1:0] A_FLAGS =
		`CEFC_IDX_TO_ADDR(`CEFC_FLAGS_IDX);
	localparam [`CEFC_ADDR_W-1:0] A_MASKS =
		`CEFC_IDX_TO_ADDR(`CEFC_MASKS_IDX);
	localparam [`CEFC_ADDR_W-1:0] A_POL =
		`CEFC_IDX_TO_ADDR(`CEFC_POL_IDX);
	localparam [`CEFC_ADDR_W-1:0] A_DB =
		`CEFC_IDX_TO_ADDR(`CEFC_DB_IDX);

	// -----------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------
	function hit;
		input [31:0]             addr;
		input [`CEFC_ADDR_W-1:0] target;
		begin
			hit = (addr[31:`CEFC_ADDR_W] == 20'h0_0000) &&
				(addr[`CEFC_ADDR_W-1:0] == target);
		end
	endfunction

	// -----------------------------------------------------------
	// Source gathering in flag bit order
	// -----------------------------------------------------------
	wire [N-1:0] src_raw;

	assign src_raw[`CEFC_BIT_BITCLK]    = BITCLK_PIN;
	assign src_raw[`CEFC_BIT_SEQ]       = SEQ_BUSY;
	assign src_raw[`CEFC_BIT_PIN_THREE] = PIN_THREE;
	assign src_raw[`CEFC_BIT_PIN_TWO]   = PIN_TWO;
	assign src_raw[`CEFC_BIT_PIN_ONE]   = PIN_ONE;
	assign src_raw[`CEFC_BIT_IN_EIGHT]  = INPUT_EIGHT;
	assign src_raw[`CEFC_BIT_IN_SEVEN]  = INPUT_SEVEN;
	assign src_raw[`CEFC_BIT_FREQ_LOCK] = FREQ_LOCK;
	assign src_raw[`CEFC_BIT_MIC_SHRT]  = MIC_SHORT;
	assign src_raw[`CEFC_BIT_MIC_DET]   = MIC_DETECT;

	// -----------------------------------------------------------
	// Registers
	// -----------------------------------------------------------
	reg  [N-1:0] sync1_r;
	reg  [N-1:0] sync2_r;
	reg  [N-1:0] prev_r;
	reg  [N-1:0] flags_r;
	reg  [N-1:0] masks_r;
	reg  [N-1:0] pol_r;
	reg  [N-1:0] db_r;
	reg          dp_valid_r;
	reg          dp_write_r;
	reg  [31:0]  dp_addr_r;
	reg  [N-1:0] flags_nxt;
	reg  [N-1:0] clr_mask;
	reg  [31:0]  rdata;
	wire [N-1:0] src_pol;
	wire [N-1:0] src_db;
	wire [N-1:0] evt_rise;
	wire         addr_phase;
	wire         wr_flags;
	wire         wr_masks;
	wire         wr_pol;
	wire         wr_db;
	wire         summary;

	// -----------------------------------------------------------
	// Input synchroniser
	// -----------------------------------------------------------
	// Sources come from pins and analogue detectors, so two flops
	// guard against metastability before any logic sees them.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_r <= {N{1'b0}};
			sync2_r <= {N{1'b0}};
		end else begin
			sync1_r <= src_raw;
			sync2_r <= sync1_r;
		end
	end

	// -----------------------------------------------------------
	// Polarity and debounce
	// -----------------------------------------------------------
	assign src_pol = sync2_r ^ pol_r;

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_db
			cefc_debounce u_db (
				.CLK     (CLK),
				.RST_N   (RST_N),
				.LVL_IN  (src_pol[g]),
				.DB_EN   (db_r[g]),
				.LVL_OUT (src_db[g])
			);
		end
	endgenerate

	// -----------------------------------------------------------
	// Event detection
	// -----------------------------------------------------------
	// An event is the active edge of the conditioned level; a
	// level that simply stays active does not re-set a flag that
	// software has cleared.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prev_r <= {N{1'b0}};
		end else begin
			prev_r <= src_db;
		end
	end

	assign evt_rise = src_db & ~prev_r;

	// -----------------------------------------------------------
	// Bus slave
	// -----------------------------------------------------------
	assign addr_phase = HSEL & HREADY & HTRANS[1];

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= 32'h0000_0000;
		end else if (HREADY) begin
			dp_valid_r <= addr_phase;
			dp_write_r <= HWRITE;
			dp_addr_r  <= HADDR;
		end
	end

	assign wr_flags = dp_valid_r & dp_write_r & hit(dp_addr_r, A_FLAGS);
	assign wr_masks = dp_valid_r & dp_write_r & hit(dp_addr_r, A_MASKS);
	assign wr_pol   = dp_valid_r & dp_write_r & hit(dp_addr_r, A_POL);
	assign wr_db    = dp_valid_r & dp_write_r & hit(dp_addr_r, A_DB);

	// Every access finishes in its first data-phase cycle.
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	// -----------------------------------------------------------
	// Flag register
	// -----------------------------------------------------------
	always @* begin
		clr_mask = {N{1'b0}};
		if (wr_flags) begin
			clr_mask = HWDATA[N-1:0];
		end
		// Clear first, then set, so a same-cycle event survives.
		flags_nxt = (flags_r & ~clr_mask) | evt_rise;
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			flags_r <= `CEFC_FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// -----------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			masks_r <= `CEFC_MASKS_RST;
			pol_r   <= `CEFC_POL_RST;
			db_r    <= `CEFC_DB_RST;
		end else begin
			if (wr_masks) begin
				masks_r <= HWDATA[N-1:0];
			end
			if (wr_pol) begin
				pol_r <= HWDATA[N-1:0];
			end
			if (wr_db) begin
				db_r <= HWDATA[N-1:0];
			end
		end
	end

	// -----------------------------------------------------------
	// Summary and interrupt output
	// -----------------------------------------------------------
	// Bit 10 has no storage, so writes to it land nowhere.
	assign summary = |flags_r;

	assign IRQ = |(flags_r & ~masks_r);

	// -----------------------------------------------------------
	// Read data
	// -----------------------------------------------------------
	// The sequencer flag is returned as stored; software must not
	// trust it while the sequencer is busy.
	always @* begin
		rdata = 32'h0000_0000;
		if (dp_valid_r && !dp_write_r) begin
			if (hit(dp_addr_r, A_FLAGS)) begin
				rdata[N-1:0] = flags_r;
				rdata[`CEFC_BIT_SUMMARY] = summary;
			end else if (hit(dp_addr_r, A_MASKS)) begin
				rdata[N-1:0] = masks_r;
			end else if (hit(dp_addr_r, A_POL)) begin
				rdata[N-1:0] = pol_r;
			end else if (hit(dp_addr_r, A_DB)) begin
				rdata[N-1:0] = db_r;
			end
		end
	end

	assign HRDATA = rdata;

endmodule // cefc_top

// ===== testbench/cefc_top_monitor.sv
`include "cefc_consts.vh"

module cefc_monitor (
	input wire        CLK,
	input wire        RST_N,
	input wire        HSEL,
	input wire [31:0] HADDR,
	input wire [1:0]  HTRANS,
	input wire        HWRITE,
	input wire [31:0] HWDATA,
	input wire        HREADY,
	input wire [31:0] HRDATA,
	input wire        IRQ
);
	localparam logic [11:0] A_FLG = `CEFC_IDX_TO_ADDR(`CEFC_FLAGS_IDX);
	localparam logic [11:0] A_MSK = `CEFC_IDX_TO_ADDR(`CEFC_MASKS_IDX);
	logic        ph_r;
	logic        wr_r;
	logic [11:0] ad_r;
	logic [9:0]  msk_r;
	wire         rf = ph_r && !wr_r && ad_r == A_FLG;
	wire         rm = ph_r && !wr_r && ad_r == A_MSK;
	wire         wp = ph_r && wr_r;

	// ------------------------------------------------
	// Shadow of the mask register, fed by bus writes
	// ------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_r <= 1'b0;
			wr_r <= 1'b0;
			ad_r <= 12'h000;
			msk_r <= 10'h3FF;
		end else if (HREADY) begin
			ph_r <= HSEL && HTRANS[1];
			wr_r <= HWRITE;
			ad_r <= HADDR[11:0];
			if (wp && ad_r == A_MSK)
				msk_r <= HWDATA[9:0];
		end
	end

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_summary_or:
		assert property (rf |-> HRDATA[10] == |HRDATA[9:0])
		else $error("summary bit differs from flag OR");
	a_flag_width:
		assert property (rf |-> HRDATA[31:11] == 21'h00_0000)
		else $error("flag read has high bits set");
	a_mask_width:
		assert property (rm |-> HRDATA[31:10] == 22'h00_0000)
		else $error("mask read has high bits set");
	a_mask_readback:
		assert property (rm |-> HRDATA[9:0] == msk_r)
		else $error("mask readback differs");
	a_irq_unmasked:
		assert property (rf |-> IRQ == |(HRDATA[9:0] & ~msk_r))
		else $error("irq not the OR of unmasked flags");
	a_irq_summary:
		assert property (rf && IRQ |-> HRDATA[10])
		else $error("irq without summary bit");
	a_irq_holds:
		assert property (IRQ && !wp |=> IRQ)
		else $error("irq dropped without a write");
	a_irq_after_reset:
		assert property ($rose(RST_N) |-> !IRQ)
		else $error("irq high out of reset");
endmodule // cefc_monitor

bind cefc_top cefc_monitor cefc_monitor_inst (
	.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
	.HREADY(HREADY), .HRDATA(HRDATA), .IRQ(IRQ)
);

// ===== testbench/cefc_top_test.sv
`include "cefc_consts.vh"

module cefc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [9:0] src;
		logic [9:0] msk;
		logic       irq;
	} cefc_row_t;
	localparam logic [11:0] A_FLG = `CEFC_IDX_TO_ADDR(`CEFC_FLAGS_IDX);
	localparam logic [11:0] A_MSK = `CEFC_IDX_TO_ADDR(`CEFC_MASKS_IDX);
	localparam logic [11:0] A_POL = `CEFC_IDX_TO_ADDR(`CEFC_POL_IDX);
	localparam logic [11:0] A_DB  = `CEFC_IDX_TO_ADDR(`CEFC_DB_IDX);
	logic        CLK = 1'b0;
	logic        RST_N = 1'b0;
	logic        HSEL = 1'b0;
	logic        HWRITE = 1'b0;
	logic [1:0]  HTRANS = 2'b00;
	logic [31:0] HADDR = 32'h0000_0000;
	logic [31:0] HWDATA = 32'h0000_0000;
	logic [9:0]  src = 10'h000;
	wire         HREADYOUT;
	wire         IRQ;
	wire [31:0]  HRDATA;
	int          n_fail = 0;
	int          checked = 0;
	// Even sources unmasked, odd ones masked but still latching; the all-source row masks every source
	cefc_row_t   rows [12] = '{
		'{10'h001, 10'h3FE, 1'b1}, '{10'h002, 10'h3FF, 1'b0},
		'{10'h004, 10'h3FB, 1'b1}, '{10'h008, 10'h3FF, 1'b0},
		'{10'h010, 10'h3EF, 1'b1}, '{10'h020, 10'h3FF, 1'b0},
		'{10'h040, 10'h3BF, 1'b1}, '{10'h080, 10'h3FF, 1'b0},
		'{10'h100, 10'h2FF, 1'b1}, '{10'h200, 10'h3FF, 1'b0},
		'{10'h3FF, 10'h3FF, 1'b0}, '{10'h030, 10'h3EF, 1'b1}};

	always #5 CLK = ~CLK;

	cefc_top cefc_top_inst (
		.CLK(CLK), .RST_N(RST_N), .BITCLK_PIN(src[9]), .SEQ_BUSY(src[8]),
		.PIN_THREE(src[7]), .PIN_TWO(src[6]), .PIN_ONE(src[5]),
		.INPUT_EIGHT(src[4]), .INPUT_SEVEN(src[3]), .FREQ_LOCK(src[2]),
		.MIC_SHORT(src[1]), .MIC_DETECT(src[0]), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
		.HRESP(), .HRDATA(HRDATA), .IRQ(IRQ));

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bounded wait for the slave to accept the current phase; ready
	// and read data are taken settled, as they stand at the edge.
	task automatic wait_rdy(output logic [31:0] d);
		int   i;
		logic rdy;
		i = 0;
		rdy = 1'b0;
		d = 32'h0000_0000;
		do begin
			@(negedge CLK);
			rdy = HREADYOUT;
			d = HRDATA;
			@(posedge CLK);
			i++;
		end while (rdy !== 1'b1 && i < 50);
		if (rdy !== 1'b1) begin
			n_fail++;
			stop_test;
		end
	endtask

	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {20'h0_0000, a};
		HWRITE <= w;
		wait_rdy(r);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= d;
		wait_rdy(r);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask

	// Hold a source pattern n cycles, then idle n cycles
	task automatic pulse(input logic [9:0] v, input int n);
		@(posedge CLK);
		src <= v;
		repeat (n) @(posedge CLK);
		src <= 10'h000;
		repeat (n) @(posedge CLK);
	endtask

	task automatic do_reset;
		RST_N <= 1'b0;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		rdc(A_FLG, 32'h0000_0000);
		rdc(A_MSK, 32'h0000_03FF);
		chk(IRQ, 32'h0000_0000);
	endtask

	// ------------------------------------------------
	// Sequence
	// ------------------------------------------------
	initial begin
		do_reset;
		foreach (rows[k]) begin
			wr(A_MSK, {22'h00_0000, rows[k].msk});
			pulse(rows[k].src, 6);
			// Read only once the sources, the sequencer too, are idle
			rdc(A_FLG, {21'h00_0000, |rows[k].src, rows[k].src});
			chk(IRQ, rows[k].irq);
			wr(A_FLG, {22'h00_0000, rows[k].src});
			rdc(A_FLG, 32'h0000_0000);
			chk(IRQ, 32'h0000_0000);
		end
		// Partial clear; the summary bit ignores writes
		wr(A_MSK, 32'h0000_0000);
		pulse(10'h3FF, 6);
		wr(A_FLG, 32'h0000_0555);
		rdc(A_FLG, 32'h0000_06AA);
		chk(IRQ, 32'h0000_0001);
		wr(A_FLG, 32'h0000_02AA);
		rdc(A_FLG, 32'h0000_0000);
		// Unmapped place: reads zero, write lost
		wr(12'h300, 32'hFFFF_FFFF);
		rdc(12'h300, 32'h0000_0000);
		rdc(A_MSK, 32'h0000_0000);
		// Inverted source: only the falling pin edge counts
		wr(A_POL, 32'h0000_0001);
		pulse(10'h000, 6);
		wr(A_FLG, 32'h0000_0001);
		@(posedge CLK);
		src <= 10'h001;
		repeat (6) @(posedge CLK);
		rdc(A_FLG, 32'h0000_0000);
		pulse(10'h000, 6);
		rdc(A_FLG, 32'h0000_0401);
		wr(A_POL, 32'h0000_0000);
		wr(A_FLG, 32'h0000_0001);
		// Debounced source: a short glitch is dropped
		wr(A_DB, 32'h0000_0002);
		pulse(10'h002, 50);
		rdc(A_FLG, 32'h0000_0000);
		pulse(10'h002, 130);
		rdc(A_FLG, 32'h0000_0402);
		chk(IRQ, 32'h0000_0001);
		// Reset in mid-run with a pending unmasked flag
		do_reset;
		stop_test;
	end
endmodule // cefc_top_test
